// file: src/psp_cfg.svh
// Constants for the pipelined SRAM port control block
// Overview of operation
// - The address, including its two low bits, is captured on a qualified rising edge and picks one location.
// - Four active-low byte-lane write selects, qualified by the write strobe, each gate one data lane and its check bit.
// - The active-low write strobe is sampled only on qualified edges and must be low to start a write.
// - Advance-or-load high on a qualified edge steps the burst counter instead of taking a new address.
// - Advance-or-load low on a qualified edge loads a new external address for that access.
// - Clock edges count, and inputs other than the burst-order strap are captured, only while the clock qualifier is low.
// - The device is selected only with the first and third chip selects low and the second high.
// - Output enable acts asynchronously: low lets the data pins drive, high tristates them.
// - Data pins stay tristated in write data phases, after a deselect and while deselected, whatever output enable says.
// - A high clock qualifier does not deselect; it freezes the previous cycle's state and pending accesses.
// - A static burst-order strap picks interleaved order when high and linear order when low.
// - Write data on the data lanes is captured into an internal data register that feeds the written location.
`ifndef PSP_CFG_SVH
`define PSP_CFG_SVH
`define PSP_ADDR_W      20
`define PSP_LANES       4
`define PSP_LANE_W      8
`define PSP_LOW_BITS    2
`define PSP_STRAP_RST   1'b1
`define PSP_BE_RST      4'h0
`endif

// file: src/psp_pkg.sv
// Types shared by the pipelined SRAM port control block
package psp_pkg;
  typedef enum logic [1:0] {
    PSP_OP_IDLE  = 2'b00,
    PSP_OP_READ  = 2'b01,
    PSP_OP_WRITE = 2'b10
  } psp_op_t;
endpackage

// file: src/psp_burst_ctr.sv
// Two-bit burst address counter with linear or interleaved ordering
`timescale 1ns/1ps
`include "psp_cfg.svh"
module psp_burst_ctr (
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_en,
  input  wire logic                     i_load,
  input  wire logic                     i_advance,
  input  wire logic [`PSP_LOW_BITS-1:0] i_base,
  input  wire logic                     i_interleave,
  output logic      [`PSP_LOW_BITS-1:0] o_next_low
);
  logic [`PSP_LOW_BITS-1:0] base_r;
  logic [`PSP_LOW_BITS-1:0] cnt_r;
  logic [`PSP_LOW_BITS-1:0] cnt_nxt;

  assign cnt_nxt = cnt_r + 2'h1;
  // Interleaved order flips low bits; linear order wraps within the burst
  assign o_next_low = i_interleave ? (base_r ^ cnt_nxt) : (base_r + cnt_nxt);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      base_r <= 2'h0;
      cnt_r  <= 2'h0;
    end else if (i_en && i_load) begin
      base_r <= i_base;
      cnt_r  <= 2'h0;
    end else if (i_en && i_advance) begin
      cnt_r  <= cnt_nxt;
    end
  end
endmodule

// file: src/psp_sram_port.sv
// Pipelined burst SRAM port: command capture, burst control, data lanes and memory strobes
`timescale 1ns/1ps
`include "psp_cfg.svh"
module psp_sram_port #(
  parameter int ADDR_W = `PSP_ADDR_W,
  parameter int LANES  = `PSP_LANES,
  parameter int LANE_W = `PSP_LANE_W
) (
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst_n,
  input  wire logic [ADDR_W-1:0]         i_addr,
  input  wire logic [LANES-1:0]          i_byte_lane_write_select_n,
  input  wire logic                      i_write_n,
  input  wire logic                      i_advance_or_load,
  input  wire logic                      i_clock_qualifier_n,
  input  wire logic                      i_chip_select_first_n,
  input  wire logic                      i_chip_select_second,
  input  wire logic                      i_chip_select_third_n,
  input  wire logic                      i_output_enable_n,
  input  wire logic                      i_burst_order,
  input  wire logic [LANES*LANE_W-1:0]   i_dq,
  output logic      [LANES*LANE_W-1:0]   o_dq,
  output logic                           o_dq_oe_n,
  input  wire logic [LANES-1:0]          i_lane_check_bits,
  output logic      [LANES-1:0]          o_lane_check_bits,
  output logic                           o_lane_check_bits_oe_n,
  output logic      [ADDR_W-1:0]         o_mem_raddr,
  output logic                           o_mem_rd,
  input  wire logic [LANES*LANE_W-1:0]   i_mem_rdata,
  input  wire logic [LANES-1:0]          i_mem_rcheck,
  output logic      [ADDR_W-1:0]         o_mem_waddr,
  output logic      [LANES-1:0]          o_mem_wbe,
  output logic      [LANES*LANE_W-1:0]   o_mem_wdata,
  output logic      [LANES-1:0]          o_mem_wcheck,
  output logic                           o_mem_wr
);
  localparam int DW = LANES * LANE_W;

  logic                en;
  logic                sel;
  logic                load;
  logic                adv;
  psp_pkg::psp_op_t    cmd_op;
  logic [ADDR_W-1:0]   cmd_addr;
  logic [LANES-1:0]    cmd_be;
  logic [`PSP_LOW_BITS-1:0] next_low;
  psp_pkg::psp_op_t    last_op_r;
  logic [ADDR_W-1:0]   last_addr_r;
  psp_pkg::psp_op_t    s1_op_r;
  logic [ADDR_W-1:0]   s1_addr_r;
  psp_pkg::psp_op_t    s2_op_r;
  logic [ADDR_W-1:0]   s2_addr_r;
  logic [LANES-1:0]    s1_be_r;
  logic [LANES-1:0]    s2_be_r;
  logic                drv_r;
  logic                mode_r;
  logic                strap_done_r;
  logic [DW-1:0]       rd_data_nxt;
  logic [LANES-1:0]    rd_check_nxt;
  logic                fwd_now;
  logic                fwd_pend;

  // Byte-lane merge: lanes whose enable is set take the newer value
  function automatic logic [DW+LANES-1:0] merge_lanes(
    input logic [DW-1:0]    old_d,
    input logic [LANES-1:0] old_c,
    input logic [DW-1:0]    new_d,
    input logic [LANES-1:0] new_c,
    input logic [LANES-1:0] be
  );
    logic [DW-1:0]    d;
    logic [LANES-1:0] c;
    d = old_d;
    c = old_c;
    for (int i = 0; i < LANES; i++) begin
      if (be[i]) begin
        d[i*LANE_W +: LANE_W] = new_d[i*LANE_W +: LANE_W];
        c[i] = new_c[i];
      end
    end
    return {c, d};
  endfunction

  assign en   = ~i_clock_qualifier_n;
  assign sel  = ~i_chip_select_first_n & i_chip_select_second & ~i_chip_select_third_n;
  assign load = ~i_advance_or_load;
  assign adv  = i_advance_or_load;

  // An advance continues the last loaded command, so an advance after a
  // deselect stays deselected until the controller loads again
  always_comb begin
    if (load) begin
      if (!sel) begin
        cmd_op = psp_pkg::PSP_OP_IDLE;
      end else if (i_write_n) begin
        cmd_op = psp_pkg::PSP_OP_READ;
      end else begin
        cmd_op = psp_pkg::PSP_OP_WRITE;
      end
      cmd_addr = i_addr;
    end else begin
      cmd_op   = last_op_r;
      cmd_addr = {last_addr_r[ADDR_W-1:`PSP_LOW_BITS], next_low};
    end
    cmd_be = (cmd_op == psp_pkg::PSP_OP_WRITE) ? ~i_byte_lane_write_select_n : `PSP_BE_RST;
  end

  psp_burst_ctr u_burst_ctr (
    .i_mclk       (i_mclk),
    .i_rst_n      (i_rst_n),
    .i_en         (en),
    .i_load       (load),
    .i_advance    (adv),
    .i_base       (i_addr[`PSP_LOW_BITS-1:0]),
    .i_interleave (mode_r),
    .o_next_low   (next_low)
  );

  // Strap is caught once after reset release; it is not expected to move later
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r       <= `PSP_STRAP_RST;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      mode_r       <= i_burst_order;
      strap_done_r <= 1'b1;
    end
  end

  // Command pipeline; an unqualified edge freezes every stage
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_op_r   <= psp_pkg::PSP_OP_IDLE;
      last_addr_r <= '0;
      s1_op_r     <= psp_pkg::PSP_OP_IDLE;
      s1_addr_r   <= '0;
      s1_be_r     <= `PSP_BE_RST;
      s2_op_r     <= psp_pkg::PSP_OP_IDLE;
      s2_addr_r   <= '0;
      s2_be_r     <= `PSP_BE_RST;
    end else if (en) begin
      last_op_r   <= cmd_op;
      last_addr_r <= cmd_addr;
      s1_op_r     <= cmd_op;
      s1_addr_r   <= cmd_addr;
      s1_be_r     <= cmd_be;
      s2_op_r     <= s1_op_r;
      s2_addr_r   <= s1_addr_r;
      s2_be_r     <= s1_be_r;
    end
  end

  // Read port: the array reads o_mem_raddr combinationally
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_raddr <= '0;
      o_mem_rd    <= 1'b0;
    end else begin
      o_mem_rd <= en && (cmd_op == psp_pkg::PSP_OP_READ);
      if (en && (cmd_op == psp_pkg::PSP_OP_READ)) begin
        o_mem_raddr <= cmd_addr;
      end
    end
  end

  // Writes not yet committed are forwarded so back-to-back traffic stays coherent
  assign fwd_now  = (s2_op_r == psp_pkg::PSP_OP_WRITE) && (s2_addr_r == s1_addr_r);
  assign fwd_pend = o_mem_wr && (o_mem_waddr == s1_addr_r);

  always_comb begin
    {rd_check_nxt, rd_data_nxt} = {i_mem_rcheck, i_mem_rdata};
    if (fwd_pend) begin
      {rd_check_nxt, rd_data_nxt} = merge_lanes(rd_data_nxt, rd_check_nxt,
                                                o_mem_wdata, o_mem_wcheck, o_mem_wbe);
    end
    if (fwd_now) begin
      {rd_check_nxt, rd_data_nxt} = merge_lanes(rd_data_nxt, rd_check_nxt,
                                                i_dq, i_lane_check_bits, s2_be_r);
    end
  end

  // Read data slot: driven only when the slot belongs to a read
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drv_r             <= 1'b0;
      o_dq              <= '0;
      o_lane_check_bits <= '0;
    end else if (en) begin
      drv_r <= (s1_op_r == psp_pkg::PSP_OP_READ);
      if (s1_op_r == psp_pkg::PSP_OP_READ) begin
        o_dq              <= rd_data_nxt;
        o_lane_check_bits <= rd_check_nxt;
      end
    end
  end

  // Output enable must act without the clock, so it gates the registered drive
  assign o_dq_oe_n              = ~(drv_r & ~i_output_enable_n);
  assign o_lane_check_bits_oe_n = ~(drv_r & ~i_output_enable_n);

  // Write data register, committed to the array one cycle later
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_wr     <= 1'b0;
      o_mem_waddr  <= '0;
      o_mem_wbe    <= `PSP_BE_RST;
      o_mem_wdata  <= '0;
      o_mem_wcheck <= '0;
    end else begin
      o_mem_wr <= en && (s2_op_r == psp_pkg::PSP_OP_WRITE);
      if (en && (s2_op_r == psp_pkg::PSP_OP_WRITE)) begin
        o_mem_waddr  <= s2_addr_r;
        o_mem_wbe    <= s2_be_r;
        o_mem_wdata  <= i_dq;
        o_mem_wcheck <= i_lane_check_bits;
      end
    end
  end

  property p_write_commit;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (en && load && sel && !i_write_n) ##1 en ##1 en |=>
        o_mem_wr && (o_mem_waddr == $past(i_addr, 3));
  endproperty
  a_write_commit: assert property (p_write_commit) else $error("write not committed on time");

  property p_write_lanes;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (en && load && sel && !i_write_n) ##1 en ##1 en |=>
        (o_mem_wbe == ~$past(i_byte_lane_write_select_n, 3));
  endproperty
  a_write_lanes: assert property (p_write_lanes) else $error("byte lanes wrong on write");

  property p_read_slot;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (en && load && sel && i_write_n) ##1 en |=> drv_r;
  endproperty
  a_read_slot: assert property (p_read_slot) else $error("read slot not driven");

  property p_deselect_quiet;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (en && load && !sel) ##1 en |=> !drv_r && o_dq_oe_n;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet) else $error("driving after deselect");

  property p_write_quiet;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (en && load && sel && !i_write_n) ##1 en |=> o_dq_oe_n && o_lane_check_bits_oe_n;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("driving in write slot");

  property p_oe_mask;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_output_enable_n |-> o_dq_oe_n;
  endproperty
  a_oe_mask: assert property (p_oe_mask) else $error("drive with output enable high");

  property p_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !en |=> $stable(s1_op_r) && $stable(s2_addr_r) && $stable(drv_r) && !o_mem_wr;
  endproperty
  a_hold: assert property (p_hold) else $error("state moved on masked edge");

  property p_load_addr;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (en && load && sel && i_write_n) |=> o_mem_rd && (o_mem_raddr == $past(i_addr));
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("new address not loaded");

  property p_advance;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (en && adv && last_op_r == psp_pkg::PSP_OP_READ) |=>
        o_mem_rd && (o_mem_raddr[ADDR_W-1:2] == $past(last_addr_r[ADDR_W-1:2]))
        && (o_mem_raddr[1:0] != $past(last_addr_r[1:0]));
  endproperty
  a_advance: assert property (p_advance) else $error("burst did not advance");
endmodule

// file: dv/psp_mem_model.sv
// Behavioural array behind the port: combinational read, lane-masked write
`timescale 1ns/1ps
module psp_mem_model (
  input  wire logic        i_mclk,
  input  wire logic [19:0] i_raddr,
  input  wire logic [19:0] i_waddr,
  input  wire logic [3:0]  i_wbe,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wcheck,
  input  wire logic        i_wr,
  output logic      [31:0] o_rdata,
  output logic      [3:0]  o_rcheck
);
  // Only 16 words: the low address bits pick one, aliasing is accepted
  logic [35:0] mem [16];
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = {~i[3:0], 28'h3C5A96F, i[3:0]};
    end
  end
  always @(posedge i_mclk) begin
    for (int l = 0; l < 4; l++) begin
      if (i_wr && i_wbe[l]) begin
        mem[i_waddr[3:0]][l*8 +: 8] <= i_wdata[l*8 +: 8];
        mem[i_waddr[3:0]][32+l]     <= i_wcheck[l];
      end
    end
  end
  assign o_rdata  = mem[i_raddr[3:0]][31:0];
  assign o_rcheck = mem[i_raddr[3:0]][35:32];
endmodule

// file: dv/tb_top.sv
// Bench for the SRAM port: host-side stimulus, scenario tasks and verdict
`timescale 1ns/1ps
module tb_top;
  localparam logic [2:0] SEL = 3'b010;
  logic        clk, rst_n, we_n, adv, cen_n, cs1_n, cs2, cs3_n, oe_n, mode;
  logic        dq_oe_n, chk_oe_n, mem_rd, mem_wr;
  logic [19:0] addr, raddr, waddr;
  logic [3:0]  bw_n, chk_in, chk_o, rchk, wbe, wchk;
  logic [31:0] dq_in, dq_o, rdata, wdata;
  int          error_cnt, checked;

  psp_sram_port dut_u (
    .i_mclk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_byte_lane_write_select_n(bw_n),
    .i_write_n(we_n), .i_advance_or_load(adv), .i_clock_qualifier_n(cen_n),
    .i_chip_select_first_n(cs1_n), .i_chip_select_second(cs2), .i_chip_select_third_n(cs3_n),
    .i_output_enable_n(oe_n), .i_burst_order(mode), .i_dq(dq_in), .o_dq(dq_o),
    .o_dq_oe_n(dq_oe_n), .i_lane_check_bits(chk_in), .o_lane_check_bits(chk_o),
    .o_lane_check_bits_oe_n(chk_oe_n), .o_mem_raddr(raddr), .o_mem_rd(mem_rd),
    .i_mem_rdata(rdata), .i_mem_rcheck(rchk), .o_mem_waddr(waddr), .o_mem_wbe(wbe),
    .o_mem_wdata(wdata), .o_mem_wcheck(wchk), .o_mem_wr(mem_wr)
  );
  psp_mem_model mem_u (
    .i_mclk(clk), .i_raddr(raddr), .i_waddr(waddr), .i_wbe(wbe), .i_wdata(wdata),
    .i_wcheck(wchk), .i_wr(mem_wr), .o_rdata(rdata), .o_rcheck(rchk)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [3:0] ck(input logic [31:0] d);
    return {d[24], d[16], d[8], d[0]};
  endfunction

  function automatic logic [35:0] iw(input int i);
    return {~i[3:0], 28'h3C5A96F, i[3:0]};
  endfunction

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One command per call; d is the write data of the command two calls back
  task automatic cyc(input logic [2:0] cs, input logic wn, input logic a,
                     input logic [19:0] ad, input logic [3:0] b, input logic [31:0] d,
                     input logic ce = 1'b0);
    @(posedge clk);
    {cs1_n, cs2, cs3_n} <= cs;
    we_n   <= wn;
    adv    <= a;
    addr   <= ad;
    bw_n   <= b;
    dq_in  <= d;
    chk_in <= ck(d);
    cen_n  <= ce;
    #1;
  endtask

  task automatic idle(input logic [31:0] d);
    cyc(3'b100, 1'b1, 1'b0, 20'h00000, 4'hF, d);
  endtask

  task automatic do_reset(input logic m);
    @(posedge clk);
    rst_n <= 1'b0;
    mode  <= m;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic t_write_read;
    logic [31:0] d0, d1, m;
    d0 = 32'h8899AABB;
    d1 = 32'h11223344;
    m  = {d0[31:16], d1[15:8], d0[7:0]};
    cyc(SEL, 1'b0, 1'b0, 20'h00004, 4'h0, 32'h0);
    cyc(SEL, 1'b0, 1'b0, 20'h00004, 4'hD, 32'h0);
    cyc(SEL, 1'b1, 1'b0, 20'h00004, 4'hF, d0);
    idle(d1);
    cmp({mem_wr, wbe, waddr, wdata, wchk}, {1'b1, 4'hF, 20'h00004, d0, ck(d0)});
    cmp({dq_oe_n, chk_oe_n}, 2'b11);
    idle(32'h0);
    cmp({mem_wr, wbe, waddr, wdata, wchk}, {1'b1, 4'h2, 20'h00004, d1, ck(d1)});
    cmp({dq_oe_n, chk_oe_n, chk_o, dq_o}, {2'b00, ck(m), m});
    // Output enable is asynchronous, so it is moved between edges here
    #5 oe_n = 1'b1;
    #1 cmp({dq_oe_n, chk_oe_n}, 2'b11);
    oe_n = 1'b0;
    #1 cmp({dq_oe_n, chk_oe_n}, 2'b00);
    idle(32'h0);
    cmp(dq_oe_n, 1'b1);
  endtask

  task automatic t_suspend;
    cyc(SEL, 1'b1, 1'b0, 20'h00007, 4'hF, 32'h0);
    cyc(SEL, 1'b0, 1'b0, 20'h00009, 4'h0, 32'h0, 1'b1);
    idle(32'h0);
    cmp({mem_rd, dq_oe_n}, 2'b01);
    idle(32'hFFFFFFFF);
    cmp({dq_oe_n, chk_o, dq_o}, {1'b0, iw(7)});
    idle(32'h0);
    // A write wrongly taken on the masked edge would commit exactly here
    cmp(mem_wr, 1'b0);
    idle(32'h0);
  endtask

  task automatic t_select;
    for (int c = 0; c < 8; c++) begin
      cyc(c[2:0], 1'b1, 1'b0, 20'h00003, 4'hF, 32'h0);
      idle(32'h0);
      idle(32'h0);
      cmp(dq_oe_n, c[2:0] != SEL);
    end
  endtask

  task automatic t_burst(input logic m);
    cyc(SEL, 1'b1, 1'b0, 20'h00011, 4'hF, 32'h0);
    cyc(SEL, 1'b1, 1'b1, 20'h00000, 4'hF, 32'h0);
    cmp({mem_rd, raddr}, {1'b1, 20'h00011});
    idle(32'h0);
    cmp({mem_rd, raddr}, {1'b1, 18'h00004, m ? 2'b00 : 2'b10});
    idle(32'h0);
    idle(32'h0);
    // Advance right after a deselect continues the idle slot, not the old burst
    cyc(SEL, 1'b1, 1'b1, 20'h00011, 4'hF, 32'h0);
    idle(32'h0);
    cmp(mem_rd, 1'b0);
    idle(32'h0);
    cmp(dq_oe_n, 1'b1);
  endtask

  task automatic end_sim;
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end

  initial begin
    {rst_n, we_n, adv, cen_n, cs1_n, cs2, cs3_n, oe_n, mode} = 9'b010010001;
    addr   = 20'h00000;
    bw_n   = 4'hF;
    dq_in  = 32'h0;
    chk_in = 4'h0;
    do_reset(1'b1);
    t_write_read();
    t_suspend();
    t_select();
    t_burst(1'b1);
    do_reset(1'b0);
    t_burst(1'b0);
    end_sim();
  end
endmodule
